// ==== pvw4_regs.vh ====
`ifndef PVW4_REGS_VH
`define PVW4_REGS_VH

// Register byte addresses
`define PVW4_OFS_CONTROL      12'h1A0
`define PVW4_OFS_BASE         12'h1A4
`define PVW4_OFS_BOUND        12'h1A8
`define PVW4_OFS_STATUS       12'h1AC
`define PVW4_OFS_XLATE        12'h1B0
`define PVW4_OFS_W            12

// Register select codes
`define PVW4_SEL_NONE         3'h0
`define PVW4_SEL_CONTROL      3'h1
`define PVW4_SEL_BASE         3'h2
`define PVW4_SEL_BOUND        3'h3
`define PVW4_SEL_STATUS       3'h4
`define PVW4_SEL_XLATE        3'h5

// Control register fields
`define PVW4_CTL_EN           31
`define PVW4_CTL_POSTED_WRITE_ALLOW         30
`define PVW4_CTL_VDW_HI       23
`define PVW4_CTL_VDW_LO       22
`define PVW4_CTL_VAS_HI       18
`define PVW4_CTL_VAS_LO       16
`define PVW4_CTL_PGM          14
`define PVW4_CTL_SUPER        12
`define PVW4_CTL_VCT          8
`define PVW4_CTL_LAS          0

// Address fields, 4 Kbyte granularity
`define PVW4_PAGE_HI          31
`define PVW4_PAGE_LO          12
`define PVW4_PAGE_W           20
`define PVW4_PAGE_ZERO        20'h00000

// Width codes
`define PVW4_VDW_8            2'h0
`define PVW4_VDW_16           2'h1
`define PVW4_VDW_32           2'h2
`define PVW4_VDW_64           2'h3
`define PVW4_VDW_RESET        2'h2

// Address space codes
`define PVW4_VAS_A16          3'h0
`define PVW4_VAS_A24          3'h1
`define PVW4_VAS_A32          3'h2
`define PVW4_VAS_RSVD3        3'h3
`define PVW4_VAS_RSVD4        3'h4
`define PVW4_VAS_CRCSR        3'h5
`define PVW4_VAS_USER1        3'h6
`define PVW4_VAS_USER2        3'h7
`define PVW4_VAS_RESET        3'h0

// Status register fields
`define PVW4_STS_CNT_HI       15
`define PVW4_STS_CNT_LO       0
`define PVW4_STS_CLAIM        16
`define PVW4_STS_POSTED       17
`define PVW4_STS_BLOCK        18
`define PVW4_STS_MBLT         19
`define PVW4_STS_RSVD_SPACE   20
`define PVW4_STS_IS_WRITE     21

`define PVW4_ZERO32           32'h00000000
`define PVW4_ONE16            16'h0001
`define PVW4_ZERO16           16'h0000

`endif

// ==== pvw4_window.v ====
// The APB register port is this design's own decision.
`include "pvw4_regs.vh"

module pvw4_window #(
  parameter CNT_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        pci_req,
  input  wire [31:0] pci_addr,
  input  wire        pci_is_io,
  input  wire        pci_is_write,
  output reg         win_done,
  output reg         win_claim,
  output reg  [31:0] vme_addr,
  output reg  [1:0]  vme_width,
  output reg  [2:0]  vme_space,
  output reg         vme_space_rsvd,
  output reg         am_program,
  output reg         am_super,
  output reg         vme_block,
  output reg         vme_mblt_ok,
  output reg         wr_posted
);

  // Register map, byte offsets on the APB side
  //   control  0x1A0  enable, posting, width, space, AM bits, cycle type
  //   base     0x1A4  lowest page claimed, bits 31 to 12
  //   bound    0x1A8  first page past the window, zero for no limit
  //   status   0x1AC  read only, result of the latest decode
  //   offset   0x1B0  page offset added on the way to the VMEbus
  // Any other offset reads zero and raises pslverr
  // Writes to unmapped offsets and to status change nothing
  //
  // Control layout
  //   bit 31     window enable, clear after reset
  //   bit 30     posted writes allowed, memory space only
  //   bits 23:22 largest VMEbus data width, 32 bit after reset
  //   bits 18:16 VMEbus address space code
  //   bit 14     program rather than data access
  //   bit 12     supervisor rather than user access
  //   bit 8      block cycles wanted
  //   bit 0      window lives in PCI I/O space
  //   all other bits read zero and ignore writes
  //
  // Status layout
  //   bits 15:0  count of claimed requests, wraps silently
  //   bit 16     latest request claimed
  //   bit 17     latest request may be posted
  //   bit 18     latest request runs block cycles
  //   bit 19     latest request may run multiplexed block cycles
  //   bit 20     space code is one of the reserved two
  //   bit 21     live write flag of the PCI side, not registered
  //
  // Bus timing
  //   pready is tied high, every access ends in its first access cycle
  //   read data is taken in the setup cycle, so prdata is a flop
  //   a write lands at the edge that closes the access phase
  //   back to back transfers need no idle cycle
  //
  // Decode timing
  //   pci_req is a one cycle strobe with address and qualifiers
  //   win_done pulses one cycle later with every decode output
  //   decode outputs hold until the next strobe
  //   a strobe may come every cycle
  //   a miss still answers, with win_claim low
  //
  // Limitations
  //   settings are read live at the strobe edge, nothing is shadowed
  //   a settings write in the same cycle as a strobe uses the old value
  //   reserved space codes are flagged, not refused; the master decides
  //   the 64 bit width never runs plain block cycles, only multiplexed
  //   the claim count keeps its low sixteen bits in the status view
  //   base above bound gives an empty window, not an error
  //   translation wraps modulo 4 Gbyte, carries out of bit 31 are lost
  //
  // Reset state
  //   control reads 0x00800000, only the width field is set
  //   base, bound and offset clear to zero
  //   decode outputs clear, width shows 32 bit, space shows A16
  //   prdata and pslverr clear, pready stays high
  //
  // Hazards
  //   changing base or bound while strobes arrive may split a burst
  //   changing the offset mid transfer moves the VMEbus address
  //   software disables the window before moving it
  //   the I/O select overrides the posting bit, never the reverse
  //   width and space are copied as written, even when reserved
  //
  // Field notes
  //   the low twelve bits of the address registers read zero
  //   upper address bits of paddr must be zero for a register hit
  //   status bit 21 follows the pin, so it may change between reads
  //   the count is sized by CNT_W; only sixteen bits are visible
  //   block and multiplexed block are never both high
  //   wr_posted implies a claimed write in memory space
  //
  // Verification hooks
  //   every decode output is visible at the top level
  //   a checker may mirror the settings from the bus alone
  //   win_done gives a clean point to compare the outputs
  //   status offers a second view of the same decode result
  //
  // Clocking
  //   one clock, pclk; every flop resets asynchronously on presetn
  //   no slower rate is needed inside this window

  // Control fields
  reg                   enable_r;
  reg                   posted_write_allow_r;
  reg [1:0]             vme_max_width_r;
  reg [2:0]             vme_space_select_r;
  reg                   program_data_qualifier_r;
  reg                   supervisor_r;
  reg                   block_cycle_select_r;
  reg                   pci_space_select_r;
  // Address windows
  reg [`PVW4_PAGE_W-1:0] window_base_r;
  reg [`PVW4_PAGE_W-1:0] window_bound_r;
  reg [`PVW4_PAGE_W-1:0] translation_offset_r;
  // Activity count of claimed accesses
  reg [CNT_W-1:0]       claim_cnt_r;

  wire [2:0]            wr_sel;
  wire [2:0]            rd_sel;
  wire                  wr_fire;
  wire                  setup;
  wire [`PVW4_PAGE_W-1:0] req_page;
  wire                  above_base;
  wire                  below_bound;
  wire                  space_match;
  wire                  hit;
  wire                  a24_a32;
  reg  [31:0]           ctl_view;
  reg  [31:0]           sts_view;
  reg  [31:0]           rd_mux;

  // Offset decode shared by read and write paths
  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      case (addr[`PVW4_OFS_W-1:0])
        `PVW4_OFS_CONTROL: reg_sel = `PVW4_SEL_CONTROL;
        `PVW4_OFS_BASE:    reg_sel = `PVW4_SEL_BASE;
        `PVW4_OFS_BOUND:   reg_sel = `PVW4_SEL_BOUND;
        `PVW4_OFS_STATUS:  reg_sel = `PVW4_SEL_STATUS;
        `PVW4_OFS_XLATE:   reg_sel = `PVW4_SEL_XLATE;
        default:           reg_sel = `PVW4_SEL_NONE;
      endcase
      // Upper address bits must be zero for a hit
      if (addr[31:`PVW4_OFS_W] != 20'h00000) begin
        reg_sel = `PVW4_SEL_NONE;
      end
    end
  endfunction

  // Block transfers are only meaningful in the A24 and A32 spaces
  function is_a24_a32;
    input [2:0] vme_space_select;
    begin
      is_a24_a32 = (vme_space_select == `PVW4_VAS_A24) || (vme_space_select == `PVW4_VAS_A32);
    end
  endfunction

  // Reserved space codes are flagged so the master side can refuse them
  function is_rsvd_space;
    input [2:0] vme_space_select;
    begin
      is_rsvd_space = (vme_space_select == `PVW4_VAS_RSVD3) || (vme_space_select == `PVW4_VAS_RSVD4);
    end
  endfunction

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pwrite;
  assign wr_sel  = reg_sel(paddr);
  assign rd_sel  = reg_sel(paddr);

  // Control register image with reserved bits as zero
  always @* begin
    ctl_view = `PVW4_ZERO32;
    ctl_view[`PVW4_CTL_EN] = enable_r;
    ctl_view[`PVW4_CTL_POSTED_WRITE_ALLOW] = posted_write_allow_r;
    ctl_view[`PVW4_CTL_VDW_HI:`PVW4_CTL_VDW_LO] = vme_max_width_r;
    ctl_view[`PVW4_CTL_VAS_HI:`PVW4_CTL_VAS_LO] = vme_space_select_r;
    ctl_view[`PVW4_CTL_PGM] = program_data_qualifier_r;
    ctl_view[`PVW4_CTL_SUPER] = supervisor_r;
    ctl_view[`PVW4_CTL_VCT] = block_cycle_select_r;
    ctl_view[`PVW4_CTL_LAS] = pci_space_select_r;
  end

  // Status image: result of the latest decode and claim count
  always @* begin
    sts_view = `PVW4_ZERO32;
    sts_view[`PVW4_STS_CNT_HI:`PVW4_STS_CNT_LO] = claim_cnt_r[15:0];
    sts_view[`PVW4_STS_CLAIM] = win_claim;
    sts_view[`PVW4_STS_POSTED] = wr_posted;
    sts_view[`PVW4_STS_BLOCK] = vme_block;
    sts_view[`PVW4_STS_MBLT] = vme_mblt_ok;
    sts_view[`PVW4_STS_RSVD_SPACE] = vme_space_rsvd;
    sts_view[`PVW4_STS_IS_WRITE] = pci_is_write;
  end

  // Read multiplexer; low twelve bits of address registers read zero
  always @* begin
    case (rd_sel)
      `PVW4_SEL_CONTROL: rd_mux = ctl_view;
      `PVW4_SEL_BASE:    rd_mux = {window_base_r, 12'h000};
      `PVW4_SEL_BOUND:   rd_mux = {window_bound_r, 12'h000};
      `PVW4_SEL_STATUS:  rd_mux = sts_view;
      `PVW4_SEL_XLATE:   rd_mux = {translation_offset_r, 12'h000};
      default:           rd_mux = `PVW4_ZERO32;
    endcase
  end

  // Bus answer; unmapped offsets read zero and report an error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `PVW4_ZERO32;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? `PVW4_ZERO32 : rd_mux;
      pslverr <= (rd_sel == `PVW4_SEL_NONE);
    end
  end

  // Register writes; status is read only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r                 <= 1'b0;
      posted_write_allow_r     <= 1'b0;
      vme_max_width_r          <= `PVW4_VDW_RESET;
      vme_space_select_r       <= `PVW4_VAS_RESET;
      program_data_qualifier_r <= 1'b0;
      supervisor_r             <= 1'b0;
      block_cycle_select_r     <= 1'b0;
      pci_space_select_r       <= 1'b0;
      window_base_r            <= `PVW4_PAGE_ZERO;
      window_bound_r           <= `PVW4_PAGE_ZERO;
      translation_offset_r     <= `PVW4_PAGE_ZERO;
    end else if (wr_fire) begin
      case (wr_sel)
        `PVW4_SEL_CONTROL: begin
          enable_r                 <= pwdata[`PVW4_CTL_EN];
          posted_write_allow_r     <= pwdata[`PVW4_CTL_POSTED_WRITE_ALLOW];
          vme_max_width_r          <= pwdata[`PVW4_CTL_VDW_HI:`PVW4_CTL_VDW_LO];
          vme_space_select_r       <= pwdata[`PVW4_CTL_VAS_HI:`PVW4_CTL_VAS_LO];
          program_data_qualifier_r <= pwdata[`PVW4_CTL_PGM];
          supervisor_r             <= pwdata[`PVW4_CTL_SUPER];
          block_cycle_select_r     <= pwdata[`PVW4_CTL_VCT];
          pci_space_select_r       <= pwdata[`PVW4_CTL_LAS];
        end
        `PVW4_SEL_BASE: begin
          window_base_r <= pwdata[`PVW4_PAGE_HI:`PVW4_PAGE_LO];
        end
        `PVW4_SEL_BOUND: begin
          window_bound_r <= pwdata[`PVW4_PAGE_HI:`PVW4_PAGE_LO];
        end
        `PVW4_SEL_XLATE: begin
          translation_offset_r <= pwdata[`PVW4_PAGE_HI:`PVW4_PAGE_LO];
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end

  // Window decode on 4 Kbyte pages
  assign req_page    = pci_addr[`PVW4_PAGE_HI:`PVW4_PAGE_LO];
  assign above_base  = (req_page >= window_base_r);
  // Zero bound means open-ended upwards
  assign below_bound = (window_bound_r == `PVW4_PAGE_ZERO) ||
                       (req_page < window_bound_r);
  assign space_match = (pci_is_io == pci_space_select_r);
  assign hit         = enable_r & space_match & above_base & below_bound;
  assign a24_a32     = is_a24_a32(vme_space_select_r);

  // Decode result registered one cycle after the request. Settings are
  // sampled live, so changing them mid-access gives a mixed result.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_done       <= 1'b0;
      win_claim      <= 1'b0;
      vme_addr       <= `PVW4_ZERO32;
      vme_width      <= `PVW4_VDW_RESET;
      vme_space      <= `PVW4_VAS_RESET;
      vme_space_rsvd <= 1'b0;
      am_program     <= 1'b0;
      am_super       <= 1'b0;
      vme_block      <= 1'b0;
      vme_mblt_ok    <= 1'b0;
      wr_posted      <= 1'b0;
      claim_cnt_r    <= {CNT_W{1'b0}};
    end else begin
      win_done <= pci_req;
      if (pci_req) begin
        win_claim <= hit;
        // Page bits translated, offset within page passes through
        vme_addr  <= {req_page + translation_offset_r,
                      pci_addr[`PVW4_PAGE_LO-1:0]};
        vme_width      <= vme_max_width_r;
        vme_space      <= vme_space_select_r;
        vme_space_rsvd <= is_rsvd_space(vme_space_select_r);
        am_program     <= program_data_qualifier_r;
        am_super       <= supervisor_r;
        // Cycle type honoured only for narrow widths in A24/A32
        vme_block   <= block_cycle_select_r & a24_a32 &
                       (vme_max_width_r != `PVW4_VDW_64);
        vme_mblt_ok <= a24_a32 & (vme_max_width_r == `PVW4_VDW_64);
        // I/O space forces coupled writes
        wr_posted   <= hit & pci_is_write & posted_write_allow_r &
                       ~pci_space_select_r;
        if (hit) begin
          claim_cnt_r <= claim_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ==== pvw4_window_asserts.sv ====
`include "pvw4_regs.vh"

module pvw4_window_asserts #(
  parameter CNT_W = 16
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pci_req,
  input logic [31:0] pci_addr,
  input logic        pci_is_io,
  input logic        pci_is_write,
  input logic        win_done,
  input logic        win_claim,
  input logic [31:0] vme_addr,
  input logic [1:0]  vme_width,
  input logic [2:0]  vme_space,
  input logic        vme_space_rsvd,
  input logic        am_program,
  input logic        am_super,
  input logic        vme_block,
  input logic        vme_mblt_ok,
  input logic        wr_posted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctl_r;
  logic [19:0] bs_r, bd_r, to_r;
  wire         wr_go = psel & penable & pwrite & pready;
  wire  [19:0] pg = pci_addr[31:12];
  wire         a2432 = (ctl_r[18:16] == 3'h1) | (ctl_r[18:16] == 3'h2);
  wire         hit = ctl_r[31] & (pci_is_io == ctl_r[0]) & (pg >= bs_r)
                     & ((bd_r == 20'h00000) | (pg < bd_r));
  // Mirror of the settings, so every decode answer can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 32'h00800000;
      bs_r  <= 20'h00000;
      bd_r  <= 20'h00000;
      to_r  <= 20'h00000;
    end else if (wr_go) begin
      if (paddr == 32'h000001A0) ctl_r <= pwdata;
      if (paddr == 32'h000001A4) bs_r <= pwdata[31:12];
      if (paddr == 32'h000001A8) bd_r <= pwdata[31:12];
      if (paddr == 32'h000001B0) to_r <= pwdata[31:12];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_done_follows: assert property (pci_req |=> win_done)
    else $error("decode answer missing");
  a_quiet_hold: assert property (!pci_req |=> !win_done && $stable(vme_addr))
    else $error("decode outputs moved without request");
  a_claim_decode: assert property (pci_req |=>
    win_claim == $past(hit))
    else $error("claim decision wrong");
  a_vme_xlate: assert property (pci_req |=>
    vme_addr == $past({pg + to_r, pci_addr[11:0]}))
    else $error("translated address wrong");
  a_width_copy: assert property (pci_req |=> vme_width == $past(ctl_r[23:22]))
    else $error("width wrong");
  a_space_code: assert property (pci_req |=> vme_space == $past(ctl_r[18:16])
    && vme_space_rsvd == $past((ctl_r[18:16] == 3'h3) | (ctl_r[18:16] == 3'h4)))
    else $error("space wrong");
  a_am_bits: assert property (pci_req |=>
    {am_program, am_super} == $past({ctl_r[14], ctl_r[12]}))
    else $error("modifier bits wrong");
  a_block_gate: assert property (pci_req |=> vme_block == $past(ctl_r[8] & a2432
    & (ctl_r[23:22] != 2'h3))) else $error("block cycle choice wrong");
  a_mblt_gate: assert property (pci_req |=>
    vme_mblt_ok == $past(a2432 & (ctl_r[23:22] == 2'h3)))
    else $error("multiplexed block choice wrong");
  a_post_rule: assert property (pci_req |=> wr_posted == $past(hit & pci_is_write
    & ctl_r[30] & ~ctl_r[0])) else $error("posting choice wrong");
endmodule

bind pvw4_window pvw4_window_asserts #(.CNT_W(CNT_W)) u_pvw4_window_asserts (.*);

// ==== pvw4_pci_master.sv ====
module pvw4_pci_master (
  input  logic        pclk,
  input  logic        win_done,
  output logic        pci_req,
  output logic [31:0] pci_addr,
  output logic        pci_is_io,
  output logic        pci_is_write
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs;
  initial begin
    hangs = 0;
    pci_req = 1'b0;
    pci_addr = 32'h00000000;
    pci_is_io = 1'b0;
    pci_is_write = 1'b0;
  end
  // One-cycle request; lines carry the inverse afterwards so stale values cannot pass
  task automatic issue(input logic [31:0] a, input logic io, input logic wr);
    int n;
    @(posedge pclk);
    pci_req <= 1'b1;
    pci_addr <= a;
    pci_is_io <= io;
    pci_is_write <= wr;
    @(posedge pclk);
    pci_req <= 1'b0;
    pci_addr <= ~a;
    pci_is_io <= ~io;
    pci_is_write <= ~wr;
    n = 0;
    while (win_done !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) hangs++;
  endtask
endmodule

// ==== testbench.sv ====
`include "pvw4_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, e, v, b;
  logic [31:0] paddr, pwdata, q;
  logic [1:0]  w;
  logic [2:0]  s;
  logic [10:0] x;
  wire  [31:0] prdata, pci_addr, vme_addr;
  wire         pready, pslverr, pci_req, pci_is_io, pci_is_write, win_done, win_claim;
  wire  [1:0]  vme_width;
  wire  [2:0]  vme_space;
  wire         vme_space_rsvd, am_program, am_super, vme_block, vme_mblt_ok, wr_posted;
  int          num_errors, tests_run;
  pvw4_window u_pvw4_window (.*);
  pvw4_pci_master u_pvw4_pci_master (.*);
  always #20 pclk = ~pclk;
  task automatic finish_test();
    num_errors += u_pvw4_pci_master.hangs;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Setup then access; hold everything until pready is seen high
  task automatic apb(input logic wt, input logic [31:0] a, d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h00000000);
    chk(nm, ex, q);
  endtask
  task automatic dec(input logic [31:0] a, input logic io, wr, ec, ep);
    u_pvw4_pci_master.issue(a, io, wr);
    chk("claim", {31'h0, ec}, {31'h0, win_claim});
    chk("posted", {31'h0, ep}, {31'h0, wr_posted});
  endtask
  function automatic logic [31:0] cw(input logic en, pw, input logic [1:0] wd,
                                     input logic [2:0] sp, input logic pm, su, vc, ls);
    return {en, pw, 6'h00, wd, 3'h0, sp, 1'b0, pm, 1'b0, su, 3'h0, vc, 7'h00, ls};
  endfunction
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PVW4_OFS_CONTROL, 32'h00800000, "ctl reset");
    rd(`PVW4_OFS_BASE, 32'h00000000, "base reset");
    rd(`PVW4_OFS_BOUND, 32'h00000000, "bound reset");
    rd(`PVW4_OFS_XLATE, 32'h00000000, "xlate reset");
    apb(1'b0, 32'h000001B4, 32'h00000000);
    chk("unmapped err", 32'h00000001, {31'h0, e});
    dec(32'h00010000, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, `PVW4_OFS_BASE, 32'h00010FFF);
    rd(`PVW4_OFS_BASE, 32'h00010000, "base low bits");
    apb(1'b1, `PVW4_OFS_BOUND, 32'h00012000);
    apb(1'b1, `PVW4_OFS_CONTROL, cw(1, 0, 2, 0, 0, 0, 0, 0));
    dec(32'h0000FFFC, 1'b0, 1'b0, 1'b0, 1'b0);
    dec(32'h00010000, 1'b0, 1'b0, 1'b1, 1'b0);
    dec(32'h00011FFC, 1'b0, 1'b0, 1'b1, 1'b0);
    dec(32'h00012000, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, `PVW4_OFS_BOUND, 32'h00000000);
    dec(32'hFFFFF000, 1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b1, `PVW4_OFS_XLATE, 32'hFFFF1234);
    dec(32'h00012345, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("vme addr", 32'h00003345, vme_addr);
    apb(1'b1, `PVW4_OFS_CONTROL, cw(1, 1, 2, 0, 0, 0, 0, 0));
    dec(32'h00010000, 1'b0, 1'b1, 1'b1, 1'b1);
    dec(32'h00010000, 1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b1, `PVW4_OFS_CONTROL, cw(1, 1, 2, 0, 0, 0, 0, 1));
    dec(32'h00010000, 1'b1, 1'b1, 1'b1, 1'b0);
    dec(32'h00010000, 1'b0, 1'b1, 1'b0, 1'b0);
    // Every width and space code, block bit varied so gating is exercised
    for (int i = 0; i < 32; i++) begin
      w = i[1:0];
      s = i[4:2];
      v = i[0] ^ i[1];
      b = (s == 3'h1) || (s == 3'h2);
      x = {w, s, (s == 3'h3) || (s == 3'h4), i[0], i[2], v & b & (w != 2'h3), b & (w == 2'h3)};
      apb(1'b1, `PVW4_OFS_CONTROL, cw(1, 0, w, s, i[0], i[2], v, 0));
      dec(32'h00010000, 1'b0, 1'b0, 1'b1, 1'b0);
      chk("fields", {21'h0, x},
          {21'h0, vme_width, vme_space, vme_space_rsvd, am_program,
          am_super, vme_block, vme_mblt_ok});
    end
    // Thirty-nine claims so far; last write flag left high by the partner
    rd(`PVW4_OFS_STATUS, 32'h00210027, "status");
    finish_test();
  end
endmodule
